// ---- sep_pkg.sv ----
// sep_pkg: constants for the serial eeprom command and protection block
// assumes nothing; shared by the top module and its array storage helper
package sep_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_BITS = 4;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_SEL_LO = 2;
  localparam int ST_SEL_HI = 3;
  localparam int ST_ARM_DEF = 7;
  // opcode fields: upper nibble zero, low three bits select
  localparam logic [3:0] OP_HI_NIBBLE = 4'h0;
  localparam logic [2:0] OP_SET_LATCH = 3'h6;
  localparam logic [2:0] OP_CLR_LATCH = 3'h4;
  localparam logic [2:0] OP_RD_STATE = 3'h5;
  localparam logic [2:0] OP_WR_STATE = 3'h1;
  localparam logic [2:0] OP_RD_ARRAY = 3'h3;
  localparam logic [2:0] OP_WR_ARRAY = 3'h2;
  // protected block lower bounds
  localparam logic [8:0] PROT_QTR_BASE = 9'h180;
  localparam logic [8:0] PROT_HALF_BASE = 9'h100;
  // internal write cycle length in system clocks (stand-in for self-timed write)
  localparam int WRITE_CYCLES = 16;
  localparam int SYNC_STAGES = 3;
  localparam logic [7:0] STATE_RESET = 8'h00;
endpackage

// ---- sep_pin_sync.sv ----
// sep_pin_sync: three-flop synchroniser for pins from outside the clock domain
// assumes clk_sys_in is the only clock; a level counts once stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none
module sep_pin_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] stage_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      stage_reg <= {3{INIT}};
    end else begin
      stage_reg <= {stage_reg[1:0], pin_in};
    end
  end

  // first stage only feeds the second
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      level_out <= INIT;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_out <= stage_reg[2];
    end
  end
endmodule
`default_nettype wire

// ---- sep_array_mem.sv ----
// sep_array_mem: flip-flop byte storage for the 512-byte array
// assumes writes arrive as single-cycle strobes from the command logic
`timescale 1ns/10ps
`default_nettype none
module sep_array_mem #(
  parameter int DEPTH = sep_pkg::MEM_DEPTH,
  parameter int AW = sep_pkg::ADDR_W
) (
  // clock
  input wire logic clk_sys_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_reg [DEPTH];

  // contents survive reset, as the array is non-volatile
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem_reg[rd_addr_in];
endmodule
`default_nettype wire

// ---- sep_eeprom_core.sv ----
// sep_eeprom_core: spi slave command decode, protection and write sequencing
// assumes serial pins are asynchronous to clk_sys_in and much slower than it
//
// Overview of operation
// - status is read-only while hardware protection is on or the write latch is 0
// - status bit 0 reads 1 while an internal write runs, else 0
// - during an internal write only read-status is decoded; other opcodes ignored
// - write latch 0 blocks every status and array change
// - reset clears the write latch
// - status bits 2 and 3 are block selection, factory 0, kept over reset
// - selection 01 protects 180h-1FFh, 10 protects 100h-1FFh, 11 protects all
// - unused status bits read 0; all eight read 1 during an internal write
// - serial input sampled on rising clock, msb first, opcode then address/data
// - output bits shift out on falling clock, msb first
// - set latch 0000x110, clear latch 0000x100, read status 0000x101
// - write status 0000x001; array read x011, write x010, a8 in opcode bit 3
// - set-latch instruction sets the write latch
// - clear-latch, write-status and array-write clear the latch on completion
// - read status repeats the eight status bits while clocking continues
// - write status needs latch 1 and no hardware protection; keeps select and arm
// - status holds its old value, except busy, until its write cycle ends
// - arm bit may fall from 1 to 0 only while the protect pin is high
// - array read streams successive bytes, wrapping from last address to 0
// - array write increments the low four address bits, wrapping in the page
// - beyond sixteen bytes, later bytes overwrite the wrapped page entries
// - protected block never written; outside it only with latch 1; pin ignored
// - hardware protection is on only while protect pin low and arm bit 1
// - chip select high: output released, idle unless a write still runs
`timescale 1ns/10ps
`default_nettype none
module sep_eeprom_core #(
  parameter int ARM_BIT = sep_pkg::ST_ARM_DEF,
  parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // serial link pins
  input wire logic chip_sel_n_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe_out,
  // protect pin, active low
  input wire logic write_protect_n_in,
  // state observation
  output logic busy_out,
  output logic [7:0] protection_state_out
);
  localparam int PW = 1 << sep_pkg::PAGE_BITS;

  typedef enum logic [2:0] {
    SEP_OPCODE, SEP_ADDR, SEP_WDATA, SEP_STATE_IN, SEP_READ_OUT, SEP_IGNORE, SEP_DONE
  } sep_phase_t;

  // synchronised pins
  // cs and wp start high, their idle level, so release of reset shows no edge
  logic cs_n_s, sck_s, si_s, wp_n_s;
  sep_pin_sync #(.INIT(1'b1)) u_sync_cs (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .pin_in(chip_sel_n_in), .level_out(cs_n_s));
  sep_pin_sync #(.INIT(1'b0)) u_sync_sck (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .pin_in(ser_clk_in), .level_out(sck_s));
  sep_pin_sync #(.INIT(1'b0)) u_sync_si (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .pin_in(ser_data_in), .level_out(si_s));
  sep_pin_sync #(.INIT(1'b1)) u_sync_wp (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .pin_in(write_protect_n_in), .level_out(wp_n_s));

  // edges count only inside a frame, so either sck idle level is safe
  logic sck_d_reg, cs_n_d_reg;
  logic sck_rise, sck_fall, cs_rise, cs_fall;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      sck_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_n_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;

  // status storage
  logic latch_reg;
  // non-volatile bits: power-up value only, reset leaves them alone
  logic sel_lo_reg = 1'b0;
  logic sel_hi_reg = 1'b0;
  logic arm_reg = 1'b0;
  logic busy_reg;
  logic [$clog2(WRITE_CYCLES+1)-1:0] wcnt_reg;
  logic hw_protect;
  logic [7:0] state_view;
  assign hw_protect = ~wp_n_s & arm_reg;

  always_comb begin
    state_view = sep_pkg::STATE_RESET;
    state_view[sep_pkg::ST_LATCH] = latch_reg;
    state_view[sep_pkg::ST_SEL_LO] = sel_lo_reg;
    state_view[sep_pkg::ST_SEL_HI] = sel_hi_reg;
    state_view[ARM_BIT] = arm_reg;
    if (busy_reg) begin
      state_view = 8'hff;
    end
  end

  // serial receive and phase control
  sep_phase_t phase_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [2:0] op_reg;
  logic [8:0] addr_reg;
  logic [7:0] tx_reg;
  logic [7:0] st_data_reg;
  logic st_pend_reg, arr_pend_reg, clr_pend_reg;
  logic [7:0] page_data_reg [PW];
  logic [PW-1:0] page_valid_reg;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] mem_rd;
  assign rx_byte = {shift_reg[6:0], si_s};
  assign byte_done = sck_rise && (bit_reg == 3'h7);

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
    end else if (cs_n_s) begin
      bit_reg <= 3'h0;
    end else if (sck_rise) begin
      shift_reg <= rx_byte;
      bit_reg <= bit_reg + 3'h1;
    end
  end

  logic [3:0] wr_off_reg;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      phase_reg <= SEP_OPCODE;
      op_reg <= 3'h0;
      addr_reg <= 9'h000;
      st_data_reg <= 8'h00;
      st_pend_reg <= 1'b0;
      arr_pend_reg <= 1'b0;
      clr_pend_reg <= 1'b0;
      page_valid_reg <= '0;
      wr_off_reg <= 4'h0;
    end else if (cs_n_s) begin
      phase_reg <= SEP_OPCODE;
      if (cs_rise) begin
        st_pend_reg <= 1'b0;
        arr_pend_reg <= 1'b0;
        clr_pend_reg <= 1'b0;
      end
    end else if (cs_fall) begin
      phase_reg <= SEP_OPCODE;
      st_pend_reg <= 1'b0;
      arr_pend_reg <= 1'b0;
      clr_pend_reg <= 1'b0;
    end else if (byte_done) begin
      case (phase_reg)
        SEP_OPCODE: begin
          op_reg <= rx_byte[2:0];
          addr_reg[8] <= rx_byte[3];
          if (rx_byte[7:4] != sep_pkg::OP_HI_NIBBLE) begin
            phase_reg <= SEP_IGNORE;
          end else if (busy_reg) begin
            phase_reg <= (rx_byte[2:0] == sep_pkg::OP_RD_STATE) ? SEP_READ_OUT : SEP_IGNORE;
          end else begin
            // kept past cs rise for the commit; cleared by the next accepted opcode
            page_valid_reg <= '0;
            case (rx_byte[2:0])
              sep_pkg::OP_SET_LATCH: phase_reg <= SEP_DONE;
              sep_pkg::OP_CLR_LATCH: begin
                phase_reg <= SEP_DONE;
                clr_pend_reg <= 1'b1;
              end
              sep_pkg::OP_RD_STATE: phase_reg <= SEP_READ_OUT;
              sep_pkg::OP_WR_STATE: phase_reg <= SEP_STATE_IN;
              sep_pkg::OP_RD_ARRAY, sep_pkg::OP_WR_ARRAY: phase_reg <= SEP_ADDR;
              default: phase_reg <= SEP_IGNORE;
            endcase
          end
        end
        SEP_ADDR: begin
          addr_reg[7:0] <= rx_byte;
          wr_off_reg <= rx_byte[3:0];
          phase_reg <= (op_reg == sep_pkg::OP_RD_ARRAY) ? SEP_READ_OUT : SEP_WDATA;
          clr_pend_reg <= (op_reg == sep_pkg::OP_WR_ARRAY);
        end
        SEP_WDATA: begin
          page_data_reg[wr_off_reg] <= rx_byte;
          page_valid_reg[wr_off_reg] <= 1'b1;
          wr_off_reg <= wr_off_reg + 4'h1;
          arr_pend_reg <= 1'b1;
        end
        SEP_STATE_IN: begin
          st_data_reg <= rx_byte;
          st_pend_reg <= 1'b1;
          clr_pend_reg <= 1'b1;
          phase_reg <= SEP_DONE;
        end
        SEP_READ_OUT: begin
          if (op_reg == sep_pkg::OP_RD_ARRAY) begin
            addr_reg <= addr_reg + 9'h001;
          end
        end
        SEP_IGNORE, SEP_DONE: phase_reg <= phase_reg;
        default: phase_reg <= SEP_IGNORE;
      endcase
    end
  end

  // output shifter: loads on the falling edge after a byte boundary
  logic oe_reg;
  logic loaded_reg;
  logic [7:0] out_src;
  assign out_src = (op_reg == sep_pkg::OP_RD_ARRAY) ? mem_rd : state_view;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tx_reg <= 8'h00;
      oe_reg <= 1'b0;
      ser_data_out <= 1'b0;
      loaded_reg <= 1'b0;
    end else if (cs_n_s || phase_reg != SEP_READ_OUT) begin
      oe_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end else if (sck_fall) begin
      oe_reg <= 1'b1;
      if (!loaded_reg || bit_reg == 3'h0) begin
        tx_reg <= {out_src[6:0], 1'b0};
        ser_data_out <= out_src[7];
        loaded_reg <= 1'b1;
      end else begin
        ser_data_out <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
  assign ser_data_oe_out = oe_reg;

  // commit at deselect, then internal write cycle
  logic go_state, go_array;
  logic [4:0] commit_idx_reg;
  logic committing_reg;
  logic [8:0] page_base_reg;
  logic blocked;
  logic mem_we;
  logic [8:0] mem_wa;
  assign go_state = cs_rise && st_pend_reg && latch_reg && !hw_protect;
  assign go_array = cs_rise && arr_pend_reg && latch_reg;
  // one page entry per clock for 16 clocks, apart from busy; WRITE_CYCLES below the page size ends busy before the commit

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      committing_reg <= 1'b0;
      commit_idx_reg <= 5'h00;
      page_base_reg <= 9'h000;
    end else if (go_array) begin
      committing_reg <= 1'b1;
      commit_idx_reg <= 5'h00;
      page_base_reg <= {addr_reg[8:4], 4'h0};
    end else if (committing_reg) begin
      commit_idx_reg <= commit_idx_reg + 5'h01;
      committing_reg <= (commit_idx_reg != 5'(PW - 1));
    end
  end

  assign mem_wa = page_base_reg | {5'h00, commit_idx_reg[3:0]};
  always_comb begin
    case ({sel_hi_reg, sel_lo_reg})
      2'b01: blocked = (mem_wa >= sep_pkg::PROT_QTR_BASE);
      2'b10: blocked = (mem_wa >= sep_pkg::PROT_HALF_BASE);
      2'b11: blocked = 1'b1;
      default: blocked = 1'b0;
    endcase
  end
  assign mem_we = committing_reg && page_valid_reg[commit_idx_reg[3:0]] && !blocked;

  sep_array_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_wa),
    .wr_data_in(page_data_reg[commit_idx_reg[3:0]]),
    .rd_addr_in(addr_reg),
    .rd_data_out(mem_rd)
  );

  // status applies on the last busy clock, so it never shows mid-cycle
  logic st_apply_reg;
  logic [7:0] st_hold_reg;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      busy_reg <= 1'b0;
      wcnt_reg <= '0;
      st_apply_reg <= 1'b0;
      st_hold_reg <= 8'h00;
    end else if (go_state || go_array) begin
      busy_reg <= 1'b1;
      wcnt_reg <= ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES);
      st_apply_reg <= go_state;
      st_hold_reg <= st_data_reg;
    end else if (busy_reg) begin
      wcnt_reg <= wcnt_reg - 1'b1;
      if (wcnt_reg == 1) begin
        busy_reg <= 1'b0;
        st_apply_reg <= 1'b0;
      end
    end
  end

  // selection and arm survive reset as non-volatile state
  always_ff @(posedge clk_sys_in) begin
    if (busy_reg && wcnt_reg == 1 && st_apply_reg) begin
      sel_lo_reg <= st_hold_reg[sep_pkg::ST_SEL_LO];
      sel_hi_reg <= st_hold_reg[sep_pkg::ST_SEL_HI];
      if (st_hold_reg[ARM_BIT] || wp_n_s) begin
        arm_reg <= st_hold_reg[ARM_BIT];
      end
    end
  end

  // a refused write still clears the latch at cs rise
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      latch_reg <= 1'b0;
    end else if (cs_rise && (clr_pend_reg || st_pend_reg || arr_pend_reg)) begin
      latch_reg <= 1'b0;
    end else if (cs_rise && phase_reg == SEP_DONE && op_reg == sep_pkg::OP_SET_LATCH
                 && !busy_reg) begin
      latch_reg <= 1'b1;
    end
  end

  assign busy_out = busy_reg;
  assign protection_state_out = state_view;
endmodule
`default_nettype wire

// ---- sep_asserts.sv ----
// sep_asserts: port-level checks on the eeprom command core
// assumes it is bound onto sep_eeprom_core; one clock, synchronous low reset
`timescale 1ns/10ps
`default_nettype none
module sep_asserts #(
  parameter int WRITE_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // watched pins and outputs
  input wire logic chip_sel_n_in,
  input wire logic ser_data_oe_out,
  input wire logic busy_out,
  input wire logic [7:0] protection_state_out
);
  int bcnt;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // length of the current busy stretch
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || !busy_out) bcnt <= 0;
    else bcnt <= bcnt + 1;
  end
  a_desel_quiet: assert property (chip_sel_n_in [*8] |-> !ser_data_oe_out)
    else $error("output driven while deselected");
  a_busy_all_ones: assert property (busy_out |-> protection_state_out == 8'hff)
    else $error("state not all ones while busy");
  a_idle_low_bits: assert property (!busy_out |-> {protection_state_out[6:4],
    protection_state_out[0]} == 4'h0)
    else $error("unused or busy bits set while idle");
  a_busy_length: assert property ($fell(busy_out) |-> bcnt == WRITE_CYCLES)
    else $error("busy stretch of wrong length");
  a_busy_on_desel: assert property ($rose(busy_out) |->
    chip_sel_n_in && $past(chip_sel_n_in, 3))
    else $error("write started while selected");
  a_latch_off_done: assert property ($fell(busy_out) |-> !protection_state_out[1])
    else $error("latch still set after write");
  a_latch_on_desel: assert property ($rose(protection_state_out[1]) && !busy_out
    |-> chip_sel_n_in)
    else $error("latch set inside a frame");
  a_state_at_desel: assert property ($changed(protection_state_out) && !busy_out
    && !$past(busy_out) |-> chip_sel_n_in)
    else $error("state changed inside a frame");
  c_write_run: cover property ($rose(busy_out));
  c_output_on: cover property ($rose(ser_data_oe_out));
  c_arm_stored: cover property ($fell(busy_out) ##1 protection_state_out[7]);
endmodule
`default_nettype wire

// ---- sep_spi_master.sv ----
// sep_spi_master: spi master partner in mode 0, or mode 3 with cpol set; sck still between frames
// assumes a 64 ns sck period, four system clocks per half
`timescale 1ns/10ps
`default_nettype none
module sep_spi_master (
  // pacing clock
  input wire logic clk_sys_in,
  // spi pins
  output logic cs_n_out,
  output logic sck_out,
  output logic mosi_out,
  input wire logic so_data_in,
  input wire logic so_oe_in
);
  logic so_last = 1'b0;
  logic miso;
  logic cpol = 1'b0;
  // released line shows the inverse of its last driven level
  assign miso = so_oe_in ? so_data_in : ~so_last;
  always @(posedge clk_sys_in) if (so_oe_in) so_last <= so_data_in;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    mosi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic select();
    // idle level settles before cs falls, so it is never taken as an edge
    sck_out = cpol;
    tick(2);
    cs_n_out = 1'b0;
    tick(6);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      // falling edge opens each bit, except the first one in mode 0
      if (cpol || i < 7) sck_out = 1'b0;
      mosi_out = tx[i];
      tick(4);
      sck_out = 1'b1;
      tick(3);
      // sampled late: output lags the fall by the pin synchroniser
      rx[i] = miso;
      tick(1);
    end
    if (!cpol) sck_out = 1'b0;
  endtask
  task automatic deselect();
    tick(4);
    cs_n_out = 1'b1;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ---- sep_eeprom_core_bench.sv ----
// sep_eeprom_core_bench: self-checking bench with a behavioural model
// assumes the spi partner model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module sep_eeprom_core_bench;
  localparam int WCYC = 400;
  typedef logic [7:0] sep_byte_q_t[$];
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wp_n = 1'b1;
  logic cs_n, sck, mosi, so_d, so_oe, busy, oe_seen;
  logic [7:0] st;
  logic [7:0] mem[int];
  logic [31:0] rng = 32'hfe2ee7be;
  int err_total = 0;
  int cmp_count = 0;
  int latch = 0;
  int sel = 0;
  int arm = 0;
  int probe[3] = '{'h0f5, 'h175, 'h1f5};
  sep_byte_q_t rxq, d;
  // long write cycle so a status read fits inside it
  sep_eeprom_core #(.WRITE_CYCLES(WCYC)) dut_u (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .chip_sel_n_in(cs_n), .ser_clk_in(sck),
    .ser_data_in(mosi), .ser_data_out(so_d), .ser_data_oe_out(so_oe),
    .write_protect_n_in(wp_n), .busy_out(busy), .protection_state_out(st));
  sep_spi_master master_u (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n), .sck_out(sck),
    .mosi_out(mosi), .so_data_in(so_d), .so_oe_in(so_oe));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (so_oe === 1'b1) oe_seen <= 1'b1;
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  function automatic bit prot(input int a);
    return sel == 3 || (sel == 2 && a >= 'h100) || (sel == 1 && a >= 'h180);
  endfunction
  function automatic logic [7:0] exp_st();
    return {arm[0], 3'h0, sel[1:0], latch[0], 1'b0};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic txn(input sep_byte_q_t tx, input int nrx);
    logic [7:0] r;
    rxq = {};
    master_u.select();
    foreach (tx[i]) master_u.xfer(tx[i], r);
    repeat (nrx) begin
      master_u.xfer(8'h00, r);
      rxq.push_back(r);
    end
    master_u.deselect();
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2 * WCYC) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk("busy", 8'h00, {7'h0, busy});
  endtask
  task automatic set_latch();
    txn('{8'h0e}, 0);
    latch = 1;
  endtask
  task automatic wr_arr(input int a, input sep_byte_q_t dq);
    sep_byte_q_t tx;
    int w;
    tx = '{{4'h0, a[8], 3'h2}, a[7:0]};
    foreach (dq[i]) begin
      tx.push_back(dq[i]);
      w = (a & 'h1f0) | ((a + i) & 'hf);
      if (latch == 1 && !prot(w)) mem[w] = dq[i];
    end
    txn(tx, 0);
    latch = 0;
  endtask
  task automatic rd_arr(input int a, input int n);
    txn('{{4'h0, a[8], 3'h3}, a[7:0]}, n);
    foreach (rxq[i]) chk("array byte", mem[(a + i) % 512], rxq[i]);
  endtask
  task automatic wr_st(input logic [7:0] v);
    set_latch();
    txn('{8'h01, v}, 0);
    if (!(wp_n == 1'b0 && arm == 1)) begin
      sel = v[3:2];
      arm = v[7];
    end
    latch = 0;
    idle();
    chk("state", exp_st(), st);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1 reset_n_in = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk("reset state", 8'h00, st);
    txn('{8'h05}, 2);
    foreach (rxq[i]) chk("read state", 8'h00, rxq[i]);
    $display("test reset done");
    set_latch();
    repeat (17) d.push_back(rnd());
    wr_arr('h1f5, d);
    chk("busy state", 8'hff, st);
    txn('{8'h0d}, 1);
    chk("busy read", 8'hff, rxq[0]);
    txn('{8'h06}, 0);
    idle();
    chk("after write", exp_st(), st);
    rd_arr('h1f0, 16);
    $display("test page done");
    set_latch();
    wr_arr(0, '{rnd()});
    idle();
    wr_arr(0, '{rnd()});
    idle();
    rd_arr('h1fe, 3);
    $display("test wrap done");
    for (int s = 0; s < 4; s++) begin
      wr_st({4'h7, s[1:0], 2'h3});
      foreach (probe[j]) begin
        set_latch();
        wr_arr(probe[j], '{rnd()});
        idle();
        rd_arr(probe[j], 1);
      end
    end
    $display("test blocks done");
    wr_st(8'h80);
    @(posedge clk_sys_in);
    #1 wp_n = 1'b0;
    wr_st(8'h0c);
    wr_st(8'h00);
    set_latch();
    wr_arr('h175, '{rnd()});
    idle();
    rd_arr('h175, 1);
    @(posedge clk_sys_in);
    #1 wp_n = 1'b1;
    wr_st(8'h00);
    $display("test pin done");
    master_u.cpol = 1'b1;
    txn('{8'h05}, 2);
    foreach (rxq[i]) chk("mode 3 state", exp_st(), rxq[i]);
    rd_arr('h1f0, 2);
    $display("test mode 3 done");
    oe_seen = 1'b0;
    txn('{8'h17, 8'h03, 8'h00}, 1);
    chk("bad op drive", 8'h00, {7'h0, oe_seen});
    chk("bad op state", exp_st(), st);
    $display("test bad opcode done");
    conclude();
  end
endmodule
bind sep_eeprom_core sep_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .chip_sel_n_in(chip_sel_n_in),
  .ser_data_oe_out(ser_data_oe_out), .busy_out(busy_out),
  .protection_state_out(protection_state_out));
`default_nettype wire
